// *** hw/tcmc_top.sv ***
/*
 * Three channel mode counter with an AHB-Lite register slave.
 * Assumes counter clock and gate pins are asynchronous to clk_sys and
 * much slower than it; each is synchronised before use.
 */
// Operation
// - Three independent counters selected 0 to 2, each with clock, gate, output.
// - Reading a count never stops, reloads or disturbs counting.
// - Counts span 0 to 65535 binary (default) and 0 to 9999 decimal.
// - Each counter selects 16-bit binary or 4-decade decimal counting.
// - Terminal level set mode drives output low and counts while gate high.
// - In that mode terminal count drives output high until a setup or clear write.
// - Single pulse mode goes low on the first counter clock after a gate rise, high at terminal count.
// - Periodic low pulse mode drives output low one clock per cycle.
// - Loaded count sets clock periods between starts of periodic pulses.
// - Half duty mode is high half the count rounded up, low the rest.
// - Software strobe starts high and counts only while gate high.
// - Software strobe terminal count drives output low for one clock.
// - Gate started strobe begins counting on a gate trigger instead.
// - A new initial count leaves mode and counting format unchanged.
// - Clear stops the counter and forces its output to 0 or 1.
`timescale 1ns/1ps
`default_nettype none
module tcmc_top
	import tcmc_pkg::*;
(
	// System.
	input wire logic clk_sys,
	input wire logic rst_n,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Counter pins.
	input wire logic [NUM_CTR-1:0] ctr_clk,
	input wire logic [NUM_CTR-1:0] ctr_gate,
	output logic [NUM_CTR-1:0] ctr_out
);
	logic ap_wr_r;
	logic [7:0] ap_addr_r;
	logic [31:0] rdata_nxt;
	logic wr_setup;
	logic wr_update;
	logic wr_clear;
	logic [1:0] wsel;
	logic [15:0] wcount;
	logic [NUM_CTR-1:0] c1_r, c2_r, c3_r, g1_r, g2_r, g3_r;
	logic [NUM_CTR-1:0] out_r, stop_r, run_r, trig_r, bcd_r;
	logic [NUM_CTR-1:0] tick, gate_rise, setup_hit, update_hit, clear_hit;
	tcmc_mode_t mode_r [NUM_CTR];
	logic [15:0] cnt_r [NUM_CTR];
	logic [15:0] init_r [NUM_CTR];
	logic [16:0] pos_r [NUM_CTR];

	wire logic addr_ok = hsel && hready && htrans[1];

	// Zero wait state slave; read data is captured in the address phase.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ap_wr_r <= 1'b0;
			ap_addr_r <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			ap_wr_r <= addr_ok && hwrite;
			ap_addr_r <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addr_ok && !hwrite) begin
				hrdata <= rdata_nxt;
			end
		end
	end

	// A count read only samples the counter state.
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		for (int k = 0; k < NUM_CTR; k++) begin
			if (haddr[7:0] == OFS_COUNT0 + 8'(4 * k)) begin
				rdata_nxt[CNT_W-1:0] = cnt_r[k];
				rdata_nxt[RD_OUT_BIT] = out_r[k];
				rdata_nxt[RD_STOP_BIT] = stop_r[k];
				rdata_nxt[RD_MODE_LSB +: 3] = mode_r[k];
				rdata_nxt[RD_RADIX_BIT] = bcd_r[k];
			end
		end
	end

	assign wr_setup = ap_wr_r && (ap_addr_r == OFS_SETUP);
	assign wr_update = ap_wr_r && (ap_addr_r == OFS_UPDATE);
	assign wr_clear = ap_wr_r && (ap_addr_r == OFS_CLEAR);
	assign wsel = hwdata[SEL_LSB +: 2];
	assign wcount = hwdata[COUNT_LSB +: CNT_W];

	// Pin synchronisers; the third stage only feeds edge detection.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			c1_r <= '0;
			c2_r <= '0;
			c3_r <= '0;
			g1_r <= '0;
			g2_r <= '0;
			g3_r <= '0;
		end else begin
			c1_r <= ctr_clk;
			c2_r <= c1_r;
			c3_r <= c2_r;
			g1_r <= ctr_gate;
			g2_r <= g1_r;
			g3_r <= g2_r;
		end
	end

	assign tick = c2_r & ~c3_r;
	assign gate_rise = g2_r & ~g3_r;
	assign ctr_out = out_r;

	for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
		logic [16:0] len;
		logic [16:0] pos_nxt;
		logic [15:0] dec;
		logic quiet;

		// Selector 3 matches no counter and the write is dropped.
		assign setup_hit[i] = wr_setup && (wsel == 2'(i));
		assign update_hit[i] = wr_update && (wsel == 2'(i));
		assign clear_hit[i] = wr_clear && (wsel == 2'(i));
		assign len = len_of(init_r[i], bcd_r[i]);
		assign pos_nxt = (pos_r[i] + 17'h00001 == len) ? 17'h00000 :
			pos_r[i] + 17'h00001;
		assign dec = cnt_dec(cnt_r[i], bcd_r[i]);
		assign quiet = !stop_r[i] && !setup_hit[i] && !update_hit[i] &&
			!clear_hit[i];

		// A gate edge arriving as the trigger is consumed is kept.
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				trig_r[i] <= 1'b0;
			end else if (setup_hit[i] || clear_hit[i]) begin
				trig_r[i] <= gate_rise[i];
			end else begin
				trig_r[i] <= gate_rise[i] || (trig_r[i] && !tick[i]);
			end
		end

		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				mode_r[i] <= MODE_TERM_LEVEL_SET;
				bcd_r[i] <= radix_two_format;
				init_r[i] <= CNT_RST;
				cnt_r[i] <= CNT_RST;
				pos_r[i] <= 17'h00000;
				out_r[i] <= 1'b0;
				stop_r[i] <= 1'b1;
				run_r[i] <= 1'b0;
			end else if (setup_hit[i]) begin
				mode_r[i] <= tcmc_mode_t'(hwdata[MODE_LSB +: 3]);
				bcd_r[i] <= hwdata[RADIX_BIT];
				init_r[i] <= wcount;
				cnt_r[i] <= wcount;
				pos_r[i] <= 17'h00000;
				stop_r[i] <= 1'b0;
				out_r[i] <= (hwdata[MODE_LSB +: 3] != MODE_TERM_LEVEL_SET);
				// A gate started strobe idles until its trigger arrives.
				run_r[i] <= (hwdata[MODE_LSB +: 3] != MODE_GATE_STARTED_STROBE);
			end else if (update_hit[i]) begin
				init_r[i] <= wcount;
				cnt_r[i] <= wcount;
				pos_r[i] <= 17'h00000;
				stop_r[i] <= 1'b0;
				run_r[i] <= (mode_r[i] != MODE_GATE_STARTED_STROBE);
			end else if (clear_hit[i]) begin
				stop_r[i] <= 1'b1;
				out_r[i] <= hwdata[LEVEL_BIT];
				run_r[i] <= 1'b0;
			end else if (!stop_r[i] && tick[i]) begin
				case (mode_r[i])
				MODE_TERM_LEVEL_SET: begin
					if (g2_r[i]) begin
						cnt_r[i] <= dec;
						if (cnt_r[i] == CNT_ONE) begin
							out_r[i] <= 1'b1;
						end
					end
				end
				MODE_GATE_FIRED_SINGLE_PULSE: begin
					if (trig_r[i]) begin
						cnt_r[i] <= init_r[i];
						out_r[i] <= 1'b0;
						run_r[i] <= 1'b1;
					end else if (run_r[i] && !out_r[i]) begin
						cnt_r[i] <= dec;
						if (cnt_r[i] == CNT_ONE) begin
							out_r[i] <= 1'b1;
							run_r[i] <= 1'b0;
						end
					end
				end
				MODE_PERIODIC_LOW_PULSE: begin
					if (g2_r[i]) begin
						if (cnt_r[i] == CNT_ONE) begin
							cnt_r[i] <= init_r[i];
							out_r[i] <= 1'b0;
						end else begin
							cnt_r[i] <= dec;
							out_r[i] <= 1'b1;
						end
					end
				end
				MODE_HALF_DUTY_DIVIDER: begin
					if (g2_r[i]) begin
						pos_r[i] <= pos_nxt;
						cnt_r[i] <= (pos_nxt == 17'h00000) ? init_r[i] : dec;
						// High holds ceil(len/2) periods.
						out_r[i] <= (pos_nxt < len - (len >> 1));
					end
				end
				MODE_SOFTWARE_STROBE: begin
					out_r[i] <= 1'b1;
					if (g2_r[i] && run_r[i]) begin
						cnt_r[i] <= dec;
						if (cnt_r[i] == CNT_ONE) begin
							out_r[i] <= 1'b0;
							run_r[i] <= 1'b0;
						end
					end
				end
				MODE_GATE_STARTED_STROBE: begin
					out_r[i] <= 1'b1;
					if (trig_r[i]) begin
						cnt_r[i] <= init_r[i];
						run_r[i] <= 1'b1;
					end else if (run_r[i]) begin
						cnt_r[i] <= dec;
						if (cnt_r[i] == CNT_ONE) begin
							out_r[i] <= 1'b0;
							run_r[i] <= 1'b0;
						end
					end
				end
				default: begin
					stop_r[i] <= 1'b1;
				end
				endcase
			end
		end

		term_level_hold_a: assert property (@(posedge clk_sys)
			disable iff (!rst_n)
			mode_r[i] == MODE_TERM_LEVEL_SET && out_r[i] && quiet |=> out_r[i])
			else $error("terminal level output dropped");
		term_level_gate_a: assert property (@(posedge clk_sys)
			disable iff (!rst_n)
			mode_r[i] == MODE_TERM_LEVEL_SET && !g2_r[i] && quiet
			|=> $stable(cnt_r[i]))
			else $error("count moved with gate low");
		read_quiet_a: assert property (@(posedge clk_sys)
			disable iff (!rst_n)
			addr_ok && !hwrite && !tick[i] && quiet |=> $stable(cnt_r[i]))
			else $error("read disturbed the count");
		update_keep_a: assert property (@(posedge clk_sys)
			disable iff (!rst_n)
			update_hit[i] |=> $stable(mode_r[i]) && $stable(bcd_r[i]) &&
			cnt_r[i] == init_r[i])
			else $error("update changed mode or missed count");
		clear_force_a: assert property (@(posedge clk_sys)
			disable iff (!rst_n)
			clear_hit[i] |=> stop_r[i] && out_r[i] == $past(hwdata[LEVEL_BIT]))
			else $error("clear did not force output");
		periodic_reload_a: assert property (@(posedge clk_sys)
			disable iff (!rst_n)
			mode_r[i] == MODE_PERIODIC_LOW_PULSE && tick[i] && g2_r[i] &&
			cnt_r[i] == CNT_ONE && quiet
			|=> !out_r[i] && cnt_r[i] == init_r[i])
			else $error("periodic pulse or reload missing");
		periodic_high_a: assert property (@(posedge clk_sys)
			disable iff (!rst_n)
			mode_r[i] == MODE_PERIODIC_LOW_PULSE && tick[i] && g2_r[i] &&
			cnt_r[i] != CNT_ONE && quiet |=> out_r[i])
			else $error("periodic low pulse too long");
		strobe_one_a: assert property (@(posedge clk_sys)
			disable iff (!rst_n)
			mode_r[i] == MODE_SOFTWARE_STROBE && tick[i] && !out_r[i] && quiet
			|=> out_r[i])
			else $error("strobe low for more than one clock");
		pulse_start_a: assert property (@(posedge clk_sys)
			disable iff (!rst_n)
			mode_r[i] == MODE_GATE_FIRED_SINGLE_PULSE && tick[i] && trig_r[i] &&
			quiet |=> !out_r[i])
			else $error("single pulse did not start");
		periodic_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
			mode_r[i] == MODE_PERIODIC_LOW_PULSE && $fell(out_r[i]));
		half_duty_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
			mode_r[i] == MODE_HALF_DUTY_DIVIDER && $rose(out_r[i]));
		gate_strobe_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
			mode_r[i] == MODE_GATE_STARTED_STROBE && $fell(out_r[i]));
		clear_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
			clear_hit[i]);
	end

	ready_okay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hreadyout && !hresp)
		else $error("slave inserted wait or error");
endmodule
`default_nettype wire

// *** hw/tcmc_pkg.sv ***
/*
 * Shared constants, mode codes and count helpers for the three channel
 * mode counter. Assumes a 32-bit register bus with word aligned offsets.
 */
`default_nettype none
package tcmc_pkg;
	localparam int unsigned NUM_CTR = 3;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned LEN_W = 17;

	// Register offsets on the bus.
	localparam logic [7:0] OFS_SETUP = 8'h00;
	localparam logic [7:0] OFS_UPDATE = 8'h04;
	localparam logic [7:0] OFS_CLEAR = 8'h08;
	localparam logic [7:0] OFS_COUNT0 = 8'h10;
	localparam logic [7:0] OFS_COUNT1 = 8'h14;
	localparam logic [7:0] OFS_COUNT2 = 8'h18;

	// Write field positions.
	localparam int unsigned SEL_LSB = 0;
	localparam int unsigned MODE_LSB = 2;
	localparam int unsigned RADIX_BIT = 5;
	localparam int unsigned LEVEL_BIT = 2;
	localparam int unsigned COUNT_LSB = 16;

	// Read layout of a count register.
	localparam int unsigned RD_OUT_BIT = 16;
	localparam int unsigned RD_STOP_BIT = 17;
	localparam int unsigned RD_MODE_LSB = 18;
	localparam int unsigned RD_RADIX_BIT = 21;

	localparam logic radix_two_format = 1'b0;
	localparam logic RADIX_DECIMAL = 1'b1;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [16:0] LEN_FULL_BIN = 17'h10000;
	localparam logic [16:0] LEN_FULL_DEC = 17'h02710;

	typedef enum logic [2:0] {
		MODE_TERM_LEVEL_SET = 3'h0,
		MODE_GATE_FIRED_SINGLE_PULSE = 3'h1,
		MODE_PERIODIC_LOW_PULSE = 3'h2,
		MODE_HALF_DUTY_DIVIDER = 3'h3,
		MODE_SOFTWARE_STROBE = 3'h4,
		MODE_GATE_STARTED_STROBE = 3'h5
	} tcmc_mode_t;

	// One count step down, with decimal digits borrowing at zero.
	function automatic logic [15:0] cnt_dec(logic [15:0] v, logic dec);
		logic [15:0] r;
		logic brw;
		r = v;
		brw = 1'b1;
		if (dec == radix_two_format) begin
			r = v - CNT_ONE;
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (brw) begin
					if (r[4*k +: 4] == 4'h0) begin
						r[4*k +: 4] = 4'h9;
					end else begin
						r[4*k +: 4] = r[4*k +: 4] - 4'h1;
						brw = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	// Loaded count as a plain number of clock periods; zero is the full span.
	function automatic logic [16:0] len_of(logic [15:0] v, logic dec);
		logic [16:0] r;
		r = {1'b0, v};
		if (dec == RADIX_DECIMAL) begin
			r = 17'(v[15:12]) * 17'h003E8 + 17'(v[11:8]) * 17'h00064
				+ 17'(v[7:4]) * 17'h0000A + 17'(v[3:0]);
		end
		if (v == CNT_RST) begin
			r = (dec == RADIX_DECIMAL) ? LEN_FULL_DEC : LEN_FULL_BIN;
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// *** verification/tcmc_top_tb.sv ***
/*
 * Self-checking bench for the three channel mode counter and its bus slave.
 * Assumes the slave answers with no wait states and that a pin change
 * reaches the counter state within three system clock edges.
 */
`timescale 1ns/1ps
`default_nettype none
module tcmc_top_tb
	import tcmc_pkg::*;
;
	logic clk_sys;
	logic rst_n;
	logic hsel;
	logic hwrite;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout;
	logic hresp;
	logic [2:0] ctr_clk;
	logic [2:0] ctr_gate;
	logic [2:0] ctr_out;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;

	tcmc_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ctr_clk(ctr_clk),
		.ctr_gate(ctr_gate), .ctr_out(ctr_out));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic give_verdict();
		$display("compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// A hang in any wait ends here rather than stalling the run.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp, input string m);
		chk({31'h0, got}, {31'h0, exp}, m);
	endtask

	// One single word transfer; read data is taken at the data phase edge.
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		do begin
			@(posedge clk_sys);
		end while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clk_sys);
		end while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic setup(input int ch, input logic [2:0] md, input logic rx,
		input logic [15:0] c);
		bus(1'b1, OFS_SETUP, {c, 10'h000, rx, md, 2'(ch)});
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic rdc(input int ch);
		bus(1'b0, OFS_COUNT0 + 8'(4 * ch), 32'h00000000);
	endtask

	// High and low are held three edges each, above the two-edge minimum.
	task automatic tick(input int ch);
		ctr_clk[ch] <= 1'b1;
		repeat (3) @(posedge clk_sys);
		ctr_clk[ch] <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic gate(input int ch, input logic v);
		ctr_gate[ch] <= v;
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic t_reset();
		chk({29'h0, ctr_out}, 32'h00000000, "outputs after reset");
		chkb(hresp, 1'b0, "slave answers okay");
		rdc(0);
		chk(rd, 32'h00020000, "count0 after reset");
		bus(1'b0, 8'h0C, 32'h00000000);
		chk(rd, 32'h00000000, "unmapped read");
	endtask

	task automatic t_level();
		setup(0, MODE_TERM_LEVEL_SET, radix_two_format, 16'h0003);
		chkb(ctr_out[0], 1'b0, "level mode starts low");
		tick(0);
		rdc(0);
		chk({16'h0, rd[15:0]}, 32'h00000003, "gate low holds");
		gate(0, 1'b1);
		tick(0);
		rdc(0);
		chk({16'h0, rd[15:0]}, 32'h00000002, "gate high counts");
		rdc(0);
		chk({16'h0, rd[15:0]}, 32'h00000002, "read leaves count");
		repeat (2) tick(0);
		chkb(ctr_out[0], 1'b1, "terminal sets high");
		repeat (3) tick(0);
		chkb(ctr_out[0], 1'b1, "level stays high");
	endtask

	task automatic t_periodic();
		gate(1, 1'b1);
		setup(1, MODE_PERIODIC_LOW_PULSE, radix_two_format, 16'h0003);
		for (int i = 0; i < 6; i++) begin
			tick(1);
			chkb(ctr_out[1], i % 3 != 2, "periodic pulse");
		end
	endtask

	task automatic t_clear();
		logic [15:0] c;
		for (int lv = 0; lv < 2; lv++) begin
			bus(1'b1, OFS_CLEAR, {29'h0, 1'(lv), 2'h1});
			repeat (2) @(posedge clk_sys);
			chkb(ctr_out[1], 1'(lv), "clear level");
			rdc(1);
			c = rd[15:0];
			tick(1);
			rdc(1);
			chk(rd & 32'h0003FFFF, {14'h0, 1'b1, 1'(lv), c}, "clear stops");
		end
	endtask

	// Two whole periods hold ceil(n/2) high ticks each, whatever the phase.
	task automatic t_half(input int n);
		int hi;
		hi = 0;
		gate(2, 1'b1);
		setup(2, MODE_HALF_DUTY_DIVIDER, radix_two_format, 16'(n));
		repeat (2 * n) begin
			tick(2);
			hi += ctr_out[2];
		end
		chk(32'(hi), 32'(n + n % 2), "divider high share");
	endtask

	task automatic t_strobe();
		gate(0, 1'b0);
		setup(0, MODE_SOFTWARE_STROBE, RADIX_DECIMAL, 16'h0010);
		chkb(ctr_out[0], 1'b1, "strobe starts high");
		tick(0);
		rdc(0);
		chk({16'h0, rd[15:0]}, 32'h00000010, "strobe gated");
		gate(0, 1'b1);
		repeat (9) tick(0);
		rdc(0);
		chk(rd & 32'h003FFFFF, 32'h00310001, "decimal count");
		tick(0);
		chkb(ctr_out[0], 1'b0, "strobe low");
		tick(0);
		chkb(ctr_out[0], 1'b1, "strobe back high");
		bus(1'b1, OFS_UPDATE, {16'h0025, 16'h0000});
		rdc(0);
		chk(rd & 32'h003EFFFF, 32'h00300025, "update keeps mode");
	endtask

	task automatic t_trig(input int ch, input logic [2:0] md);
		logic lo;
		logic back;
		lo = 1'b0;
		back = 1'b0;
		gate(ch, 1'b0);
		setup(ch, md, radix_two_format, 16'h0002);
		repeat (3) tick(ch);
		chkb(ctr_out[ch], 1'b1, "waits for trigger");
		gate(ch, 1'b1);
		repeat (6) begin
			tick(ch);
			back = back | (lo && ctr_out[ch] === 1'b1);
			lo = lo | (ctr_out[ch] === 1'b0);
		end
		chkb(lo, 1'b1, "triggered low");
		chkb(back, 1'b1, "high after terminal");
	endtask

	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h00000000;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		ctr_clk = 3'h0;
		ctr_gate = 3'h0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_level();
		t_periodic();
		t_clear();
		t_half(4);
		t_half(5);
		t_strobe();
		t_trig(1, MODE_GATE_FIRED_SINGLE_PULSE);
		t_trig(2, MODE_GATE_STARTED_STROBE);
		give_verdict();
	end
endmodule
`default_nettype wire
